/* File: hdl/csm_defines.vh */
`ifndef CSM_DEFINES_VH
`define CSM_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSM_OFS_CTL0    6'h00
`define CSM_OFS_CTL1    6'h01
`define CSM_OFS_BTR0    6'h02
`define CSM_OFS_BTR1    6'h03
`define CSM_OFS_RFLG    6'h04
`define CSM_OFS_RIER    6'h05
`define CSM_OFS_TFLG    6'h06
`define CSM_OFS_TIER    6'h07
`define CSM_OFS_TARQ    6'h08
`define CSM_OFS_TAAK    6'h09
`define CSM_OFS_TBSEL   6'h0A
`define CSM_OFS_IDAC    6'h0B
`define CSM_OFS_RXERR   6'h0E
`define CSM_OFS_TXERR   6'h0F
`define CSM_OFS_CODE_LO 6'h10
`define CSM_OFS_MASK_LO 6'h14
`define CSM_OFS_CODE_HI 6'h18
`define CSM_OFS_MASK_HI 6'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSM_C0_RXFRM    7
`define CSM_C0_RXACT    6
`define CSM_C0_HALTW    5
`define CSM_C0_SYNC     4
`define CSM_C0_TIMER    3
`define CSM_C0_WAKE_EN  2
`define CSM_C0_SLP_RQ   1
`define CSM_C0_INIT_RQ  0
`define CSM_RF_WAKE     7
`define CSM_RF_RXFULL   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSM_RST_CTL0    8'h01
`define CSM_RST_CTL1    6'h00
`define CSM_RST_BYTE    8'h00
`define CSM_RST_TFLG    3'h7
`define CSM_RST_TBUF    3'h0

// ----------------------------------------------------------------
// Synchronisation counts
// ----------------------------------------------------------------
`define CSM_REC_BITS    4'd11
`define CSM_BUSOFF_OCC  8'd128

`endif

/* File: hdl/csm_mode_ctrl.v */
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "csm_defines.vh"

// Overview of operation
// - Sleep acknowledge is set only when receiver idle and all transmit buffers empty.
// - Setting the sleep request is refused while the wake-up flag is pending.
// - Sleep holds until software clears request; wake enable lets bus activity clear it.
// - Init request aborts any frame at once and drops bus synchronisation.
// - Entry into initialization is shown by init acknowledge reading one.
// - In initialization the listed registers return to reset defaults.
// - Timing, mode 1 and acceptance registers are writable only in initialization.
// - Error counters are not touched by entering or leaving initialization.
// - After init exit, 11 recessive bits give synchronisation when not bus-off.
// - When bus-off, 128 runs of 11 recessive bits are needed to rejoin.
// - Transmit pin goes recessive in stop, or in wait with halt-in-wait set.
// - Transmit pin goes recessive at once when initialization is requested.
// - Clearing the sleep request is ignored until sleep is acknowledged.
// - Clearing the init request is ignored until init is acknowledged.
// - Transmitter and receiver status fields survive initialization entry.
// - Sleep acknowledge clears when sleep is left; sleep needs both bits set.
module csm_mode_ctrl (
   input  wire       sys_clk,
   input  wire       rst,
   input  wire [5:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       rx_pin,
   input  wire       core_tx,
   input  wire       core_rx_busy,
   input  wire       core_rx_done,
   input  wire       core_rx_full,
   input  wire [2:0] core_tx_done,
   input  wire [2:0] core_abort_done,
   input  wire       core_bus_off,
   input  wire       core_bit_tick,
   input  wire [1:0] core_tx_state,
   input  wire [1:0] core_rx_state,
   input  wire [7:0] core_tx_err,
   input  wire [7:0] core_rx_err,
   input  wire       cpu_wait,
   input  wire       cpu_stop,
   output reg        tx_pin,
   output reg        core_abort,
   output reg        sleep_active,
   output reg        synced
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg       rx_s1_r;
   reg       rx_s2_r;
   reg [7:0] ctl0_r;
   reg [5:0] ctl1_r;
   reg       sleep_ack_r;
   reg       init_ack_r;
   reg [7:0] btr0_r;
   reg [7:0] btr1_r;
   reg [7:0] idac_r;
   reg [7:0] code_r [0:7];
   reg [7:0] mask_r [0:7];
   reg       wake_flag_r;
   reg       rx_full_r;
   reg [7:0] rier_r;
   reg [2:0] tflg_r;
   reg [2:0] tier_r;
   reg [2:0] tarq_r;
   reg [2:0] taak_r;
   reg [2:0] tbsel_r;
   reg [1:0] tstat_r;
   reg [1:0] rstat_r;
   reg [7:0] tx_err_r;
   reg [7:0] rx_err_r;
   reg [3:0] rec_cnt_r;
   reg [7:0] occ_cnt_r;
   reg       sync_r;
   reg [7:0] rd_nxt;
   integer   i;

   // Both bits of a request/acknowledge pair set means the mode is in force.
   function mode_on;
      input rq;
      input ak;
      begin
         mode_on = rq & ak;
      end
   endfunction

   wire       init_rq    = ctl0_r[`CSM_C0_INIT_RQ];
   wire       slp_rq     = ctl0_r[`CSM_C0_SLP_RQ];
   wire       in_init    = mode_on(init_rq, init_ack_r);
   wire       in_sleep   = mode_on(slp_rq, sleep_ack_r);
   wire       init_out   = ~init_rq & ~init_ack_r;
   wire       wr_c0      = reg_wr & (reg_addr == `CSM_OFS_CTL0);
   wire       bus_idle   = ~core_rx_busy & (tflg_r == `CSM_RST_TFLG);
   wire       wake_evt   = in_sleep & ctl0_r[`CSM_C0_WAKE_EN] & ~rx_s2_r;
   wire       wr_init_ok = reg_wr & in_init;
   wire [2:0] acc_idx    = {reg_addr[3], reg_addr[1:0]};
   wire       acc_hit    = (reg_addr[5:4] == 2'b01);
   wire [7:0] c0_dflt    = `CSM_RST_CTL0;

   // Init request as it will stand after this edge, so the pin reacts on the same edge.
   reg init_nxt;
   always @* begin
      init_nxt = init_rq;
      if (wr_c0) begin
         if (reg_wdata[`CSM_C0_INIT_RQ])
            init_nxt = 1'b1;
         else if (in_init)
            init_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bus pin synchroniser and core status capture
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_s1_r  <= 1'b1;
         rx_s2_r  <= 1'b1;
         tstat_r  <= 2'b00;
         rstat_r  <= 2'b00;
         tx_err_r <= `CSM_RST_BYTE;
         rx_err_r <= `CSM_RST_BYTE;
      end else begin
         rx_s1_r  <= rx_pin;
         rx_s2_r  <= rx_s1_r;
         tstat_r  <= core_tx_state;
         rstat_r  <= core_rx_state;
         tx_err_r <= core_tx_err;
         rx_err_r <= core_rx_err;
      end
   end

   // ----------------------------------------------------------------
   // Control register 0 and the mode handshakes
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl0_r      <= `CSM_RST_CTL0;
         sleep_ack_r <= 1'b0;
         init_ack_r  <= 1'b0;
      end else begin
         ctl0_r[`CSM_C0_INIT_RQ] <= init_nxt;
         init_ack_r <= init_rq;
         if (in_init) begin
            // Everything but wake enable and the two requests is held at reset.
            ctl0_r[7:3] <= c0_dflt[7:3];
         end else begin
            if (core_rx_done)
               ctl0_r[`CSM_C0_RXFRM] <= 1'b1;
            else if (wr_c0 && init_out && reg_wdata[`CSM_C0_RXFRM])
               ctl0_r[`CSM_C0_RXFRM] <= 1'b0;
            if (wr_c0 && init_out) begin
               ctl0_r[`CSM_C0_HALTW] <= reg_wdata[`CSM_C0_HALTW];
               ctl0_r[`CSM_C0_TIMER] <= reg_wdata[`CSM_C0_TIMER];
            end
         end
         if (wr_c0 && init_out)
            ctl0_r[`CSM_C0_WAKE_EN] <= reg_wdata[`CSM_C0_WAKE_EN];
         // Bus activity wins over any software write of the sleep request.
         if (wake_evt)
            ctl0_r[`CSM_C0_SLP_RQ] <= 1'b0;
         else if (wr_c0 && init_out) begin
            if (reg_wdata[`CSM_C0_SLP_RQ] && !wake_flag_r)
               ctl0_r[`CSM_C0_SLP_RQ] <= 1'b1;
            else if (!reg_wdata[`CSM_C0_SLP_RQ] && in_sleep)
               ctl0_r[`CSM_C0_SLP_RQ] <= 1'b0;
         end
         if (!slp_rq || wake_evt)
            sleep_ack_r <= 1'b0;
         else if (bus_idle)
            sleep_ack_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registers writable only in initialization mode
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl1_r <= `CSM_RST_CTL1;
         btr0_r <= `CSM_RST_BYTE;
         btr1_r <= `CSM_RST_BYTE;
         idac_r <= `CSM_RST_BYTE;
         for (i = 0; i < 8; i = i + 1) begin
            code_r[i] <= `CSM_RST_BYTE;
            mask_r[i] <= `CSM_RST_BYTE;
         end
      end else if (wr_init_ok) begin
         if (reg_addr == `CSM_OFS_CTL1)
            ctl1_r <= reg_wdata[7:2];
         if (reg_addr == `CSM_OFS_BTR0)
            btr0_r <= reg_wdata;
         if (reg_addr == `CSM_OFS_BTR1)
            btr1_r <= reg_wdata;
         if (reg_addr == `CSM_OFS_IDAC)
            idac_r <= reg_wdata;
         if (acc_hit && !reg_addr[2])
            code_r[acc_idx] <= reg_wdata;
         if (acc_hit && reg_addr[2])
            mask_r[acc_idx] <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Flag, enable and buffer registers cleared by initialization
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wake_flag_r <= 1'b0;
         rx_full_r   <= 1'b0;
         rier_r      <= `CSM_RST_BYTE;
         tflg_r      <= `CSM_RST_TFLG;
         tier_r      <= `CSM_RST_TBUF;
         tarq_r      <= `CSM_RST_TBUF;
         taak_r      <= `CSM_RST_TBUF;
         tbsel_r     <= `CSM_RST_TBUF;
      end else if (in_init) begin
         wake_flag_r <= 1'b0;
         rx_full_r   <= 1'b0;
         rier_r      <= `CSM_RST_BYTE;
         tflg_r      <= `CSM_RST_TFLG;
         tier_r      <= `CSM_RST_TBUF;
         tarq_r      <= `CSM_RST_TBUF;
         taak_r      <= `CSM_RST_TBUF;
         tbsel_r     <= `CSM_RST_TBUF;
      end else begin
         // Hardware sets beat software clears arriving in the same cycle.
         if (wake_evt)
            wake_flag_r <= 1'b1;
         else if (reg_wr && init_out && reg_addr == `CSM_OFS_RFLG &&
                  reg_wdata[`CSM_RF_WAKE])
            wake_flag_r <= 1'b0;
         if (core_rx_full)
            rx_full_r <= 1'b1;
         else if (reg_wr && init_out && reg_addr == `CSM_OFS_RFLG &&
                  reg_wdata[`CSM_RF_RXFULL])
            rx_full_r <= 1'b0;
         if (reg_wr && init_out && reg_addr == `CSM_OFS_RIER)
            rier_r <= reg_wdata;
         if (reg_wr && init_out && reg_addr == `CSM_OFS_TIER)
            tier_r <= reg_wdata[2:0];
         if (reg_wr && init_out && reg_addr == `CSM_OFS_TBSEL)
            tbsel_r <= reg_wdata[2:0];
         if (reg_wr && init_out && reg_addr == `CSM_OFS_TFLG)
            tflg_r <= (tflg_r & ~reg_wdata[2:0]) | core_tx_done;
         else
            tflg_r <= tflg_r | core_tx_done;
         if (reg_wr && init_out && reg_addr == `CSM_OFS_TARQ)
            tarq_r <= (tarq_r | reg_wdata[2:0]) & ~core_abort_done;
         else
            tarq_r <= tarq_r & ~core_abort_done;
         taak_r <= (taak_r | core_abort_done) & ~core_tx_done;
      end
   end

   // ----------------------------------------------------------------
   // Bus synchronisation after initialization exit
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rec_cnt_r <= 4'd0;
         occ_cnt_r <= 8'd0;
         sync_r    <= 1'b0;
      end else if (init_nxt || init_rq || init_ack_r) begin
         rec_cnt_r <= 4'd0;
         occ_cnt_r <= 8'd0;
         sync_r    <= 1'b0;
      end else if (!sync_r && core_bit_tick) begin
         if (!rx_s2_r) begin
            rec_cnt_r <= 4'd0;
         end else if (rec_cnt_r == `CSM_REC_BITS - 4'd1) begin
            rec_cnt_r <= 4'd0;
            if (!core_bus_off)
               sync_r <= 1'b1;
            else if (occ_cnt_r == `CSM_BUSOFF_OCC - 8'd1)
               sync_r <= 1'b1;
            else
               occ_cnt_r <= occ_cnt_r + 8'd1;
         end else begin
            rec_cnt_r <= rec_cnt_r + 4'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin and core outputs
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_pin       <= 1'b1;
         core_abort   <= 1'b1;
         sleep_active <= 1'b0;
         synced       <= 1'b0;
      end else begin
         // Recessive is forced on the very edge that takes the init write.
         if (init_nxt)
            tx_pin <= 1'b1;
         else if (cpu_stop || (cpu_wait && ctl0_r[`CSM_C0_HALTW]))
            tx_pin <= 1'b1;
         else
            tx_pin <= core_tx;
         core_abort   <= init_nxt;
         sleep_active <= in_sleep & ~wake_evt;
         // Synchronisation is dropped on the edge that takes the init write.
         synced       <= sync_r & ~init_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always @* begin
      rd_nxt = 8'h00;
      if (acc_hit)
         rd_nxt = reg_addr[2] ? mask_r[acc_idx] : code_r[acc_idx];
      case (reg_addr)
         `CSM_OFS_CTL0:  rd_nxt = {ctl0_r[7], core_rx_busy, ctl0_r[5], sync_r,
                                   ctl0_r[3:0]};
         `CSM_OFS_CTL1:  rd_nxt = {ctl1_r, sleep_ack_r, init_ack_r};
         `CSM_OFS_BTR0:  rd_nxt = btr0_r;
         `CSM_OFS_BTR1:  rd_nxt = btr1_r;
         `CSM_OFS_RFLG:  rd_nxt = {wake_flag_r, 1'b0, rstat_r, tstat_r, 1'b0,
                                   rx_full_r};
         `CSM_OFS_RIER:  rd_nxt = rier_r;
         `CSM_OFS_TFLG:  rd_nxt = {5'h00, tflg_r};
         `CSM_OFS_TIER:  rd_nxt = {5'h00, tier_r};
         `CSM_OFS_TARQ:  rd_nxt = {5'h00, tarq_r};
         `CSM_OFS_TAAK:  rd_nxt = {5'h00, taak_r};
         `CSM_OFS_TBSEL: rd_nxt = {5'h00, tbsel_r};
         `CSM_OFS_IDAC:  rd_nxt = idac_r;
         `CSM_OFS_RXERR: rd_nxt = rx_err_r;
         `CSM_OFS_TXERR: rd_nxt = tx_err_r;
         default:        rd_nxt = rd_nxt;
      endcase
   end

   // Read data stand only in the cycle after the strobe; otherwise zero.
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_nxt : 8'h00;
   end

endmodule

/* File: sim/can_sleep_init_mode_control_bench.sv */
`timescale 1ns/1ps
`include "csm_defines.vh"
module can_sleep_init_mode_control_bench;
   reg        sys_clk, rst, reg_wr, reg_rd, core_tx, core_rx_busy;
   reg        core_bus_off, cpu_wait, cpu_stop, dominant;
   reg  [5:0] reg_addr;
   reg  [7:0] reg_wdata, v, core_tx_err, core_rx_err;
   reg  [1:0] core_tx_state, core_rx_state;
   reg  [3:0] pins;
   wire [7:0] reg_rdata;
   wire       rx_pin, core_bit_tick, tx_pin, core_abort, sleep_active, synced;
   integer    error_cnt, checked;
   csm_mode_ctrl u_csm_mode_ctrl (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_pin(rx_pin), .core_tx(core_tx), .core_rx_busy(core_rx_busy),
      .core_rx_done(1'b0), .core_rx_full(1'b0), .core_tx_done(3'h0),
      .core_abort_done(3'h0), .core_bus_off(core_bus_off), .core_bit_tick(core_bit_tick),
      .core_tx_state(core_tx_state), .core_rx_state(core_rx_state),
      .core_tx_err(core_tx_err), .core_rx_err(core_rx_err), .cpu_wait(cpu_wait),
      .cpu_stop(cpu_stop), .tx_pin(tx_pin), .core_abort(core_abort),
      .sleep_active(sleep_active), .synced(synced));
   csm_bus_model u_csm_bus_model (.sys_clk(sys_clk), .rst(rst), .dominant(dominant),
      .rx_pin(rx_pin), .bit_tick(core_bit_tick));
   // Pins are captured mid-cycle so a check never races the edge that moves them.
   always @(negedge sys_clk) pins <= {tx_pin, core_abort, sleep_active, synced};
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
      end
   endtask
   task chk(input string nm, input [7:0] exp, input [7:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   task wr2(input [5:0] a, input [7:0] d0, input [7:0] d1);
      begin
         reg_addr  <= a;
         reg_wdata <= d0;
         reg_wr    <= 1'b1;
         @(posedge sys_clk);
         reg_wdata <= d1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      begin
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task rd(input [5:0] a, output [7:0] d);
      begin
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 d = reg_rdata;
         @(posedge sys_clk);
      end
   endtask
   task rchk(input string nm, input [5:0] a, input [7:0] exp);
      reg [7:0] r;
      begin
         rd(a, r);
         chk(nm, exp, r);
      end
   endtask
   task t_config;
      begin
         rchk("ctl0", `CSM_OFS_CTL0, 8'h01);
         rchk("ctl1", `CSM_OFS_CTL1, 8'h01);
         wr(`CSM_OFS_BTR0, 8'h5A);
         rchk("btr0", `CSM_OFS_BTR0, 8'h5A);
         wr(`CSM_OFS_CODE_HI, 8'hC3);
         rchk("code", `CSM_OFS_CODE_HI, 8'hC3);
         wr(`CSM_OFS_TIER, 8'h03);
         rchk("tier", `CSM_OFS_TIER, 8'h00);
         core_tx <= 1'b0;
         wr(`CSM_OFS_CTL0, 8'h00);
         rchk("ctl1", `CSM_OFS_CTL1, 8'h00);
         chk("txpin", 8'h00, {7'd0, pins[3]});
         wr(`CSM_OFS_BTR0, 8'h33);
         rchk("btr0", `CSM_OFS_BTR0, 8'h5A);
         rchk("hole", 6'h0C, 8'h00);
         chk("sync", 8'h00, {7'd0, pins[0]});
         cyc(60);
         rchk("ctl0", `CSM_OFS_CTL0, 8'h10);
      end
   endtask
   task t_sleep;
      begin
         wr(`CSM_OFS_TIER, 8'h03);
         rchk("tier", `CSM_OFS_TIER, 8'h03);
         wr(`CSM_OFS_RIER, 8'h80);
         core_rx_busy <= 1'b1;
         wr(`CSM_OFS_CTL0, 8'h06);
         cyc(3);
         rchk("ctl1", `CSM_OFS_CTL1, 8'h00);
         wr(`CSM_OFS_CTL0, 8'h04);
         rd(`CSM_OFS_CTL0, v);
         chk("ctl0", 8'h06, v & 8'h0F);
         core_rx_busy <= 1'b0;
         cyc(3);
         rchk("ctl1", `CSM_OFS_CTL1, 8'h02);
         chk("sleep", 8'h01, {7'd0, pins[1]});
         dominant <= 1'b1;
         cyc(6);
         dominant <= 1'b0;
         chk("sleep", 8'h00, {7'd0, pins[1]});
         rchk("ctl1", `CSM_OFS_CTL1, 8'h00);
         rd(`CSM_OFS_CTL0, v);
         chk("ctl0", 8'h04, v & 8'h0F);
         rchk("rflg", `CSM_OFS_RFLG, 8'h98);
         wr(`CSM_OFS_CTL0, 8'h06);
         rd(`CSM_OFS_CTL0, v);
         chk("ctl0", 8'h04, v & 8'h0F);
      end
   endtask
   task t_init;
      begin
         core_bus_off <= 1'b1;
         wr2(`CSM_OFS_CTL0, 8'h07, 8'h06);
         chk("pins", 8'h0C, {4'd0, pins & 4'hD});
         rchk("ctl1", `CSM_OFS_CTL1, 8'h01);
         rchk("tier", `CSM_OFS_TIER, 8'h00);
         rchk("rflg", `CSM_OFS_RFLG, 8'h18);
         rchk("txerr", `CSM_OFS_TXERR, 8'h5C);
         rchk("rxerr", `CSM_OFS_RXERR, 8'h3A);
         rchk("ctl0", `CSM_OFS_CTL0, 8'h05);
         wr(`CSM_OFS_CTL0, 8'h04);
         cyc(5300);
         chk("sync", 8'h00, {7'd0, pins[0]});
         cyc(400);
         chk("sync", 8'h01, {7'd0, pins[0]});
      end
   endtask
   task t_halt;
      begin
         core_bus_off <= 1'b0;
         cpu_stop     <= 1'b1;
         cyc(2);
         chk("txpin", 8'h01, {7'd0, pins[3]});
         cpu_stop <= 1'b0;
         cpu_wait <= 1'b1;
         cyc(2);
         chk("txpin", 8'h00, {7'd0, pins[3]});
         wr(`CSM_OFS_CTL0, 8'h24);
         cyc(1);
         chk("txpin", 8'h01, {7'd0, pins[3]});
         cpu_wait <= 1'b0;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt = error_cnt + 1;
      stop_test;
   end
   initial begin
      error_cnt = 0;
      checked = 0;
      {rst, reg_wr, reg_rd, core_tx, core_rx_busy} = 5'b10010;
      {core_bus_off, cpu_wait, cpu_stop, dominant} = 4'b0000;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      core_tx_err = 8'h5C;
      core_rx_err = 8'h3A;
      core_tx_state = 2'b10;
      core_rx_state = 2'b01;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(2);
      t_config;
      t_sleep;
      t_init;
      t_halt;
      stop_test;
   end
endmodule

/* File: sim/csm_bus_model.sv */
`timescale 1ns/1ps
module csm_bus_model (
   input  wire sys_clk,
   input  wire rst,
   input  wire dominant,
   output reg  rx_pin,
   output reg  bit_tick
);
   reg [1:0] div_r;
   // A bit time of four clocks keeps the long bus-off wait affordable.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r    <= 2'd0;
         bit_tick <= 1'b0;
         rx_pin   <= 1'b1;
      end else begin
         div_r    <= div_r + 2'd1;
         bit_tick <= (div_r == 2'd3);
         rx_pin   <= ~dominant;
      end
   end
endmodule

/* File: sim/csm_mode_checker.sv */
`timescale 1ns/1ps
`include "csm_defines.vh"
module csm_mode_checker (
   input wire       sys_clk,
   input wire       rst,
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       rx_pin,
   input wire       core_rx_busy,
   input wire [7:0] core_tx_err,
   input wire       cpu_stop,
   input wire       tx_pin,
   input wire       core_abort,
   input wire       sleep_active,
   input wire       synced
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   wire wr_c0 = reg_wr && (reg_addr == `CSM_OFS_CTL0);
   sequence s_init_set;
      wr_c0 && reg_wdata[0];
   endsequence
   // Abort low in the set cycle and the one before, so the acknowledge is known to be low.
   sequence s_early_clr;
      (!core_abort)[*2] ##0 s_init_set ##1 (wr_c0 && !reg_wdata[0]);
   endsequence
   // Five quiet cycles cover the receive synchroniser before the wake edge.
   sequence s_quiet;
      (rx_pin && !wr_c0)[*5];
   endsequence
   property p_init_tx;
      s_init_set |=> tx_pin;
   endproperty
   a_init_tx: assert property (p_init_tx) else $error("tx not recessive");
   property p_init_abort;
      s_init_set |=> core_abort && !synced;
   endproperty
   a_init_abort: assert property (p_init_abort) else $error("no abort");
   property p_stop_tx;
      cpu_stop |=> tx_pin;
   endproperty
   a_stop_tx: assert property (p_stop_tx) else $error("tx active in stop");
   property p_sleep_idle;
      $rose(sleep_active) |-> !$past(core_rx_busy, 2);
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) else $error("sleep while busy");
   property p_sleep_hold;
      s_quiet ##0 sleep_active |=> sleep_active;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep lost");
   property p_err_keep;
      ($stable(core_tx_err))[*3] ##0 (reg_rd && reg_addr == `CSM_OFS_TXERR)
         |=> reg_rdata == $past(core_tx_err);
   endproperty
   a_err_keep: assert property (p_err_keep) else $error("error count bad");
   property p_init_clr_ign;
      s_early_clr |=> core_abort;
   endproperty
   a_init_clr_ign: assert property (p_init_clr_ign) else $error("early clear");
   property p_no_sync_init;
      core_abort |=> !synced;
   endproperty
   a_no_sync_init: assert property (p_no_sync_init) else $error("sync in init");
endmodule
bind csm_mode_ctrl csm_mode_checker u_csm_mode_checker (.sys_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_pin, .core_rx_busy, .core_tx_err,
   .cpu_stop, .tx_pin, .core_abort, .sleep_active, .synced);
